//--- verilog/nbp_pkg.sv
// nbp_pkg: constants and carriers for the binary navigation payload framer
package nbp_pkg;
  // header
  localparam logic [31:0] NBP_SYNC        = 32'h4E494224; // sync string, first byte in low lane
  localparam logic [15:0] NBP_ID_POSVEL   = 16'h0001;
  localparam logic [15:0] NBP_ID_QUALITY  = 16'h0002;
  localparam logic [15:0] NBP_ID_AUGMSG   = 16'h0050;
  localparam logic [15:0] NBP_LEN_POSVEL  = 16'h0034;  // 52 bytes
  localparam logic [15:0] NBP_LEN_QUALITY = 16'h0010;  // 16 bytes
  localparam logic [15:0] NBP_LEN_AUGMSG  = 16'h0028;  // 40 bytes
  localparam logic [7:0]  NBP_CR          = 8'h0D;
  localparam logic [7:0]  NBP_LF          = 8'h0A;
  localparam logic [7:0]  NBP_HDR_BYTES   = 8'h08;
  localparam logic [7:0]  NBP_TRL_BYTES   = 8'h04;
  localparam logic [7:0]  NBP_MAX_SATS    = 8'h0C;     // 12
  localparam logic [7:0]  NBP_AUG_PRN_OFS = 8'h78;     // 120
  localparam int          NBP_AUG_WORDS   = 8;
  localparam int          NBP_FIFO_DEPTH  = 16;
  localparam int          NBP_FIFO_WIDTH  = 8;
  // mode word fields
  localparam int          NBP_MODE_MARK_BIT = 7;
  // augmentation mask fields
  localparam int NBP_AM_TRK1 = 0;
  localparam int NBP_AM_TRK2 = 1;
  localparam int NBP_AM_USE1 = 2;
  localparam int NBP_AM_USE2 = 3;
  localparam int NBP_AM_PRN1 = 5;
  localparam int NBP_AM_PRN2 = 10;
  // slow-rate gate: 40 MHz clock, slow messages no faster than 1 Hz
  localparam longint NBP_CLK_HZ       = 40000000;
  localparam longint NBP_SLOW_RATE_HZ = 1;
  localparam longint NBP_SLOW_CYCLES  = NBP_CLK_HZ / NBP_SLOW_RATE_HZ;

  typedef enum logic [2:0] {
    NBP_NAV_NOFIX = 3'h0, NBP_NAV_2D = 3'h1, NBP_NAV_3D = 3'h2, NBP_NAV_2D_DIFF = 3'h3,
    NBP_NAV_3D_DIFF = 3'h4, NBP_NAV_RTK_SRCH = 3'h5, NBP_NAV_3D_RTK = 3'h6
  } nbp_navmode_t;

  typedef struct packed {
    logic [7:0]   diff_age_short;
    logic [7:0]   sats_in_solution;
    logic [15:0]  week_number;
    logic [63:0]  time_of_week_s;
    logic [63:0]  latitude;
    logic [63:0]  longitude;
    logic [31:0]  height;
    logic [31:0]  vel_north;
    logic [31:0]  vel_east;
    logic [31:0]  vel_up;
    logic [31:0]  residual_sigma;
    nbp_navmode_t nav_mode;
    logic         manual_mark;
    logic [15:0]  diff_age_wide;
  } nbp_posvel_t;

  typedef struct packed {
    logic [31:0] tracked_sv_mask;
    logic [31:0] solution_sv_mask;
    logic [15:0] system_utc_offset_s;
    logic [15:0] horiz_precision_x10;
    logic [15:0] vert_precision_x10;
    logic        aug1_tracked;
    logic        aug2_tracked;
    logic        aug1_used;
    logic        aug2_used;
    logic [7:0]  aug1_prn;
    logic [7:0]  aug2_prn;
  } nbp_quality_t;

  typedef struct packed {
    logic [15:0]  aug_prn;
    logic [31:0]  aug_msg_second;
    logic [249:0] aug_msg_bits;   // bit 249 received first
  } nbp_augmsg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } nbp_byte_t;
endpackage : nbp_pkg

//--- verilog/nbp_fifo.sv
// nbp_fifo: synchronous valid/ready fifo holding framed bytes
module nbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             do_wr;
  logic             do_rd;

  // handshakes
  assign o_wr_ready = (count_ff != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_ff != '0);
  assign do_wr      = i_wr_valid & o_wr_ready;
  assign do_rd      = o_rd_valid & i_rd_ready;
  assign o_rd_data  = mem_ff[rd_ptr_ff];

  // storage array
  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= i_wr_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (do_rd) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : nbp_fifo

//--- verilog/nbp_rate_gate.sv
// nbp_rate_gate: holds off slow-class messages until the slow period elapsed
module nbp_rate_gate #(
  parameter longint PERIOD = 40000000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_fire,
  output logic      o_open
);
  logic [31:0] cnt_ff;

  assign o_open = (cnt_ff == 32'h0);

  // counts down after each emitted slow message
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= 32'h0;
    end else if (i_fire) begin
      cnt_ff <= 32'(PERIOD - 1);
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end
endmodule : nbp_rate_gate

//--- verilog/nbp_framer.sv
// nbp_framer: builds binary navigation messages byte by byte into an output fifo
module nbp_framer (
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  nbp_pkg::nbp_posvel_t  i_posvel,
  input  wire logic          i_posvel_req,
  output logic               o_posvel_ack,
  input  nbp_pkg::nbp_quality_t i_quality,
  input  wire logic          i_quality_req,
  output logic               o_quality_ack,
  input  nbp_pkg::nbp_augmsg_t  i_augmsg,
  input  wire logic          i_augmsg_req,
  output logic               o_augmsg_ack,
  output logic               o_busy,
  output logic               o_sats_clamped,
  output nbp_pkg::nbp_byte_t o_byte,
  output logic               o_byte_valid,
  input  wire logic          i_byte_ready
);
  import nbp_pkg::*;

  localparam int PL_BITS = 416; // widest payload, 52 bytes

  typedef enum logic [1:0] {
    NBP_ST_IDLE = 2'b00,
    NBP_ST_HDR  = 2'b01,
    NBP_ST_PAY  = 2'b11,
    NBP_ST_TRL  = 2'b10
  } nbp_state_t;

  nbp_state_t          state_ff;
  logic [PL_BITS-1:0]  payload_ff;   // byte 0 in bits 7:0
  logic [63:0]         header_ff;    // byte 0 in bits 7:0
  logic [15:0]         length_ff;
  logic [15:0]         sum_ff;
  logic [7:0]          idx_ff;
  logic                sats_clamped_ff;
  logic [7:0]          cur_byte;
  logic                cur_last;
  logic                push;
  logic                fifo_ready;
  logic                slow_open;
  logic                slow_fire;
  logic                take_pv;
  logic                take_ql;
  logic                take_am;
  logic [PL_BITS-1:0]  pv_pay;
  logic [PL_BITS-1:0]  ql_pay;
  logic [PL_BITS-1:0]  am_pay;
  nbp_byte_t           fifo_in;
  logic [8:0]          fifo_out;

  // byte-swap helpers keep every field least significant byte first
  function automatic logic [15:0] le16(input logic [15:0] v);
    le16 = {v[7:0], v[15:8]};
  endfunction : le16

  function automatic logic [31:0] le32(input logic [31:0] v);
    le32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : le32

  function automatic logic [63:0] le64(input logic [63:0] v);
    le64 = {le32(v[31:0]), le32(v[63:32])};
  endfunction : le64

  // clamp of the satellite count to the legal range
  function automatic logic [7:0] sat_clamp(input logic [7:0] n);
    sat_clamp = (n > NBP_MAX_SATS) ? NBP_MAX_SATS : n;
  endfunction : sat_clamp

  // builds the payload images; assembled MSB-first then reversed so byte 0 sits low
  function automatic logic [PL_BITS-1:0] byte_rev(input logic [PL_BITS-1:0] v);
    for (int i = 0; i < PL_BITS/8; i++) begin
      byte_rev[i*8 +: 8] = v[PL_BITS-8-i*8 +: 8];
    end
  endfunction : byte_rev

  // position payload image
  always_comb begin
    logic [15:0] mode_word;
    logic [15:0] wide_age;
    mode_word = 16'h0000;
    mode_word[2:0] = i_posvel.nav_mode;
    mode_word[NBP_MODE_MARK_BIT] = i_posvel.manual_mark;
    wide_age = i_posvel.diff_age_wide;
    pv_pay = byte_rev({i_posvel.diff_age_short,
                       sat_clamp(i_posvel.sats_in_solution),
                       le16(i_posvel.week_number),
                       le64(i_posvel.time_of_week_s),
                       le64(i_posvel.latitude),
                       le64(i_posvel.longitude),
                       le32(i_posvel.height),
                       le32(i_posvel.vel_north),
                       le32(i_posvel.vel_east),
                       le32(i_posvel.vel_up),
                       le32(i_posvel.residual_sigma),
                       le16(mode_word),
                       le16(wide_age)});
  end

  // quality payload image, unused tail padded with zero
  always_comb begin
    logic [15:0] aug_mask;
    aug_mask = 16'h0000;
    aug_mask[NBP_AM_TRK1] = i_quality.aug1_tracked;
    aug_mask[NBP_AM_TRK2] = i_quality.aug2_tracked;
    aug_mask[NBP_AM_USE1] = i_quality.aug1_used;
    aug_mask[NBP_AM_USE2] = i_quality.aug2_used;
    aug_mask[NBP_AM_PRN1 +: 5] = 5'(i_quality.aug1_prn - NBP_AUG_PRN_OFS);
    aug_mask[NBP_AM_PRN2 +: 5] = 5'(i_quality.aug2_prn - NBP_AUG_PRN_OFS);
    ql_pay = byte_rev({le32(i_quality.tracked_sv_mask),
                       le32(i_quality.solution_sv_mask),
                       le16(i_quality.system_utc_offset_s),
                       le16(i_quality.horiz_precision_x10),
                       le16(i_quality.vert_precision_x10),
                       le16(aug_mask),
                       288'h0});
  end

  // broadcast payload image
  always_comb begin
    logic [255:0] words;
    words = {i_augmsg.aug_msg_bits, 6'h00};
    am_pay = '0;
    am_pay[PL_BITS-1 -: 64] = {le16(i_augmsg.aug_prn), 16'h0000,
                               le32(i_augmsg.aug_msg_second)};
    for (int w = 0; w < NBP_AUG_WORDS; w++) begin
      am_pay[PL_BITS-65-w*32 -: 32] = le32(words[255-w*32 -: 32]);
    end
    am_pay = byte_rev(am_pay);
  end

  // request arbitration: position first, slow ones only when the gate is open
  assign take_pv   = (state_ff == NBP_ST_IDLE) & i_posvel_req;
  assign take_ql   = (state_ff == NBP_ST_IDLE) & ~i_posvel_req & i_quality_req & slow_open;
  assign take_am   = (state_ff == NBP_ST_IDLE) & ~i_posvel_req & ~i_quality_req
                     & i_augmsg_req & slow_open;
  assign slow_fire = take_ql | take_am;
  assign o_posvel_ack  = take_pv;
  assign o_quality_ack = take_ql;
  assign o_augmsg_ack  = take_am;
  assign o_busy        = (state_ff != NBP_ST_IDLE);
  assign o_sats_clamped = sats_clamped_ff;

  // current byte selection
  always_comb begin
    cur_byte = 8'h00;
    cur_last = 1'b0;
    unique case (state_ff)
      NBP_ST_IDLE: cur_byte = 8'h00;
      NBP_ST_HDR:  cur_byte = header_ff[idx_ff[2:0]*8 +: 8];
      NBP_ST_PAY:  cur_byte = payload_ff[7:0];
      NBP_ST_TRL: begin
        unique case (idx_ff[1:0])
          2'h0: cur_byte = sum_ff[7:0];
          2'h1: cur_byte = sum_ff[15:8];
          2'h2: cur_byte = NBP_CR;
          2'h3: cur_byte = NBP_LF;
        endcase
        cur_last = (idx_ff[1:0] == 2'h3);
      end
    endcase
  end

  assign push    = (state_ff != NBP_ST_IDLE) & fifo_ready;
  assign fifo_in = '{data: cur_byte, last: cur_last};

  // framing sequencer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= NBP_ST_IDLE;
      idx_ff   <= 8'h00;
    end else begin
      unique case (state_ff)
        NBP_ST_IDLE: begin
          idx_ff <= 8'h00;
          if (take_pv | take_ql | take_am) state_ff <= NBP_ST_HDR;
        end
        NBP_ST_HDR: if (push) begin
          idx_ff <= (idx_ff == NBP_HDR_BYTES - 8'h1) ? 8'h00 : idx_ff + 8'h1;
          if (idx_ff == NBP_HDR_BYTES - 8'h1) state_ff <= NBP_ST_PAY;
        end
        NBP_ST_PAY: if (push) begin
          idx_ff <= (idx_ff == length_ff[7:0] - 8'h1) ? 8'h00 : idx_ff + 8'h1;
          if (idx_ff == length_ff[7:0] - 8'h1) state_ff <= NBP_ST_TRL;
        end
        NBP_ST_TRL: if (push) begin
          idx_ff <= idx_ff + 8'h1;
          if (idx_ff == NBP_TRL_BYTES - 8'h1) state_ff <= NBP_ST_IDLE;
        end
      endcase
    end
  end

  // message capture and payload shifting
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      payload_ff <= '0;
      header_ff  <= 64'h0;
      length_ff  <= 16'h0000;
    end else if (take_pv) begin
      payload_ff <= pv_pay;
      length_ff  <= NBP_LEN_POSVEL;
      header_ff  <= {NBP_LEN_POSVEL, NBP_ID_POSVEL, NBP_SYNC};
    end else if (take_ql) begin
      payload_ff <= ql_pay;
      length_ff  <= NBP_LEN_QUALITY;
      header_ff  <= {NBP_LEN_QUALITY, NBP_ID_QUALITY, NBP_SYNC};
    end else if (take_am) begin
      payload_ff <= am_pay;
      length_ff  <= NBP_LEN_AUGMSG;
      header_ff  <= {NBP_LEN_AUGMSG, NBP_ID_AUGMSG, NBP_SYNC};
    end else if ((state_ff == NBP_ST_PAY) & push) begin
      payload_ff <= payload_ff >> 8;
    end
  end

  // running payload checksum
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sum_ff <= 16'h0000;
    end else if (take_pv | take_ql | take_am) begin
      sum_ff <= 16'h0000;
    end else if ((state_ff == NBP_ST_PAY) & push) begin
      sum_ff <= sum_ff + {8'h00, cur_byte};
    end
  end

  // flags a position request whose satellite count had to be clamped
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sats_clamped_ff <= 1'b0;
    end else if (take_pv) begin
      sats_clamped_ff <= (i_posvel.sats_in_solution > NBP_MAX_SATS);
    end
  end

  // minimum spacing between slow-class messages
  nbp_rate_gate #(
    .PERIOD (NBP_SLOW_CYCLES)
  ) u_gate (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_fire    (slow_fire),
    .o_open    (slow_open)
  );

  // output buffering
  nbp_fifo #(
    .WIDTH (NBP_FIFO_WIDTH + 1),
    .DEPTH (NBP_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_nrst     (i_nrst),
    .i_wr_data  (fifo_in),
    .i_wr_valid (push),
    .o_wr_ready (fifo_ready),
    .o_rd_data  (fifo_out),
    .o_rd_valid (o_byte_valid),
    .i_rd_ready (i_byte_ready)
  );

  assign o_byte = nbp_byte_t'(fifo_out);
endmodule : nbp_framer

//--- verif/nbp_framer_properties.sv
// nbp_framer_properties: port level assertions for the payload framer
module nbp_framer_properties
  import nbp_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_posvel_req,
  input  wire logic          o_posvel_ack,
  input  wire logic          i_quality_req,
  input  wire logic          o_quality_ack,
  input  wire logic          o_augmsg_ack,
  input  wire logic          o_busy,
  input  nbp_pkg::nbp_byte_t o_byte,
  input  wire logic          o_byte_valid,
  input  wire logic          i_byte_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic       slow;
  logic [7:0] prev_ff;
  logic       first_ff;
  logic       seen_ff;
  longint     gap_ff;
  assign take = o_byte_valid && i_byte_ready;
  assign slow = o_quality_ack || o_augmsg_ack;
  // last byte taken and whether the next byte opens a frame
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_ff  <= 8'h00;
      first_ff <= 1'b1;
    end else if (take) begin
      prev_ff  <= o_byte.data;
      first_ff <= o_byte.last;
    end
  end
  // cycles since the last slow message was taken, saturating
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_ff <= 1'b0;
      gap_ff  <= 0;
    end else if (slow) begin
      seen_ff <= 1'b1;
      gap_ff  <= 0;
    end else if (gap_ff < NBP_SLOW_CYCLES) begin
      gap_ff <= gap_ff + 1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_lf_taken;
    take && o_byte.last;
  endsequence
  sequence s_stalled;
    o_byte_valid && !i_byte_ready;
  endsequence
  a_lf_closes: assert property (s_lf_taken |-> o_byte.data == NBP_LF)
    else $error("frame closed by a byte other than line feed");
  a_cr_before_lf: assert property (s_lf_taken |-> prev_ff == NBP_CR)
    else $error("line feed not preceded by carriage return");
  a_sync_opens: assert property (take && first_ff |-> o_byte.data == NBP_SYNC[7:0])
    else $error("frame does not open with the sync string");
  a_stall_hold: assert property (s_stalled |=> o_byte_valid && $stable(o_byte))
    else $error("byte output changed while stalled");
  a_ack_pulse: assert property (o_posvel_ack |-> i_posvel_req ##1 (!o_posvel_ack && o_busy))
    else $error("position ack without request or not one cycle");
  a_single_ack: assert property ($onehot0({o_posvel_ack, o_quality_ack, o_augmsg_ack}))
    else $error("two requests taken at once");
  a_fast_first: assert property (slow |-> !i_posvel_req && !(o_augmsg_ack && i_quality_req))
    else $error("request priority broken");
  a_slow_gap: assert property (slow |-> !seen_ff || gap_ff >= NBP_SLOW_CYCLES - 2)
    else $error("slow message taken too soon");
endmodule : nbp_framer_properties

bind nbp_framer nbp_framer_properties u_props (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_posvel_req(i_posvel_req),
  .o_posvel_ack(o_posvel_ack), .i_quality_req(i_quality_req),
  .o_quality_ack(o_quality_ack), .o_augmsg_ack(o_augmsg_ack), .o_busy(o_busy),
  .o_byte(o_byte), .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready)
);

//--- verif/nbp_host_model.sv
// nbp_host_model: host side byte consumer that stalls on command and keeps what it took
module nbp_host_model
  import nbp_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_stall,
  input  nbp_pkg::nbp_byte_t i_byte,
  input  wire logic          i_byte_valid,
  output logic               o_byte_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx[$];
  int         frames = 0;
  logic [1:0] ph_ff;
  // ready phase counter, ready high one cycle in four while stalling
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) ph_ff <= 2'h0;
    else ph_ff <= ph_ff + 2'h1;
  end
  assign o_byte_ready = i_nrst && !(i_stall && ph_ff != 2'h3);
  // bytes kept in arrival order, a frame ends at its line feed
  always @(posedge i_ref_clk) begin
    if (i_nrst && i_byte_valid && o_byte_ready) begin
      rx.push_back({i_byte.last, i_byte.data});
      if (i_byte.last) frames++;
    end
  end
endmodule : nbp_host_model

//--- verif/nbp_framer_test.sv
// nbp_framer_test: directed bench for the binary payload framer
module nbp_framer_test
  import nbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         pv_req = 1'b0;
  logic         q_req = 1'b0;
  logic         a_req = 1'b0;
  logic         stall = 1'b0;
  nbp_posvel_t  pv = '0;
  nbp_quality_t qu = '0;
  nbp_augmsg_t  am = '0;
  logic         pv_ack, q_ack, a_ack, busy, clamped, bvalid, bready;
  nbp_byte_t    ob;
  logic [7:0]   pl[$];
  int           err_total = 0;
  int           compares = 0;
  int           cyc = 0;
  nbp_framer DUT (
    .i_ref_clk(clk), .i_nrst(nrst), .i_posvel(pv), .i_posvel_req(pv_req),
    .o_posvel_ack(pv_ack), .i_quality(qu), .i_quality_req(q_req), .o_quality_ack(q_ack),
    .i_augmsg(am), .i_augmsg_req(a_req), .o_augmsg_ack(a_ack), .o_busy(busy),
    .o_sats_clamped(clamped), .o_byte(ob), .o_byte_valid(bvalid), .i_byte_ready(bready)
  );
  nbp_host_model host (
    .i_ref_clk(clk), .i_nrst(nrst), .i_stall(stall), .i_byte(ob),
    .i_byte_valid(bvalid), .o_byte_ready(bready)
  );
  always #12.5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // append a field to the expected payload, low byte first
  task automatic put(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) pl.push_back(v[8*i +: 8]);
  endtask : put
  // hold one request from a falling edge up to its ack edge; ack is looked at mid-cycle
  task automatic request(input int k);
    int t;
    t = 0;
    @(negedge clk);
    pv_req = (k == 0);
    q_req = (k == 1);
    a_req = (k == 2);
    #1;
    while ({a_ack, q_ack, pv_ack} !== 3'(1 << k) && t < 100) begin
      @(negedge clk);
      #1;
      t++;
    end
    check({a_ack, q_ack, pv_ack}, 16'(1 << k));
    @(negedge clk);
    {pv_req, q_req, a_req} = 3'h0;
  endtask : request
  // wait for one frame at the host and compare it byte by byte
  task automatic expect_frame(input logic [15:0] id);
    logic [7:0]  ex[$];
    logic [15:0] sum;
    int          n, t;
    n = host.frames;
    t = 0;
    sum = 16'h0000;
    foreach (pl[i]) sum += 16'(pl[i]);
    ex = {8'h24, 8'h42, 8'h49, 8'h4E, id[7:0], id[15:8], 8'(pl.size()), 8'(pl.size() >> 8)};
    ex = {ex, pl, sum[7:0], sum[15:8], 8'h0D, 8'h0A};
    while (host.frames == n && t < 3000) begin
      @(posedge clk);
      t++;
    end
    @(negedge clk);
    check(16'(host.rx.size()), 16'(ex.size()));
    foreach (ex[i]) check(16'(host.rx[i]), {7'h00, i == ex.size() - 1, ex[i]});
    check(busy, 1'b0);
    host.rx.delete();
    pl.delete();
  endtask : expect_frame
  // every navigation mode, counts over twelve, stalling host on odd rounds
  task automatic t_posvel_modes;
    for (int m = 0; m < 7; m++) begin
      stall = m[0];
      pv = {101{4'hB}};
      pv.sats_in_solution = 8'(10 + m);
      pv.nav_mode = nbp_navmode_t'(m);
      pv.manual_mark = m[1];
      pv.diff_age_wide = (m == 3) ? 16'h0000 : 16'(m * 300);
      put(pv.diff_age_short, 1);
      put((m > 2) ? 8'h0C : pv.sats_in_solution, 1);
      put(pv.week_number, 2);
      put(pv.time_of_week_s, 8);
      put(pv.latitude, 8);
      put(pv.longitude, 8);
      put(pv.height, 4);
      put(pv.vel_north, 4);
      put(pv.vel_east, 4);
      put(pv.vel_up, 4);
      put(pv.residual_sigma, 4);
      put({8'h00, pv.manual_mark, 4'h0, 3'(m)}, 2);
      put(pv.diff_age_wide, 2);
      request(0);
      expect_frame(16'h0001);
      check(clamped, m > 2);
    end
  endtask : t_posvel_modes
  // quality frame, then a broadcast request that the rate gate must refuse
  task automatic t_quality_gate;
    logic seen;
    seen = 1'b0;
    qu = {33{4'h6}};
    {qu.aug1_tracked, qu.aug2_tracked, qu.aug1_used, qu.aug2_used} = 4'h9;
    qu.aug1_prn = 8'h83;
    qu.aug2_prn = 8'h86;
    put(qu.tracked_sv_mask, 4);
    put(qu.solution_sv_mask, 4);
    put(qu.system_utc_offset_s, 2);
    put(qu.horiz_precision_x10, 2);
    put(qu.vert_precision_x10, 2);
    put({1'b0, 5'(qu.aug2_prn - 8'h78), 5'(qu.aug1_prn - 8'h78), 1'b0, qu.aug2_used,
         qu.aug1_used, qu.aug2_tracked, qu.aug1_tracked}, 2);
    request(1);
    expect_frame(16'h0002);
    a_req = 1'b1;
    repeat (200) begin
      @(negedge clk);
      if (a_ack !== 1'b0) seen = 1'b1;
    end
    check(seen, 1'b0);
    a_req = 1'b0;
  endtask : t_quality_gate
  // reset in mid run reopens the gate, then a broadcast frame
  task automatic t_augmsg;
    logic [255:0] w;
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    stall = 1'b1;
    am = {149{2'b10}};
    am.aug_prn = 16'h0087;
    w = {am.aug_msg_bits, 6'h00};
    put(am.aug_prn, 2);
    put(16'h0000, 2);
    put(am.aug_msg_second, 4);
    for (int i = 0; i < 8; i++) put(w[255 - 32*i -: 32], 4);
    request(2);
    expect_frame(16'h0050);
  endtask : t_augmsg
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_posvel_modes();
    t_quality_gate();
    t_augmsg();
    conclude();
  end
endmodule : nbp_framer_test
